/* File: sco_host_model.sv */
// host-side model: makes the conversion clock and captures the word
// assumes a core clock far faster than the conversion clock it makes
`timescale 1ns/1ns

module sco_host_model
	import sco_pkg::*;
#(
	parameter int HALF = 10
)
(
	// clock and run control
	input  wire logic              core_clk_in,
	input  wire logic              run_in,
	// device output pins
	input  wire sco_pkg::sco_word_t data_in,
	input  wire logic              data_oe_in,
	// clock pin and captured word
	output logic                   conv_clk_out = 1'b0,
	output logic                   rise_out     = 1'b0,
	output sco_pkg::sco_word_t     cap_out      = 8'h00
);
	int cnt = 0;

	// free-running clock; a floating bus reads back as the inverse of the last captured word
	always @(posedge core_clk_in) begin
		rise_out <= 1'b0;
		cnt <= (!run_in || cnt == HALF - 1) ? 0 : cnt + 1;
		if (run_in && cnt == HALF - 1) begin
			conv_clk_out <= ~conv_clk_out;
			if (!conv_clk_out) begin
				rise_out <= 1'b1;
				cap_out  <= data_oe_in ? data_in : ~cap_out;
			end
		end
	end
endmodule : sco_host_model

/* File: sco_map.svh */
// constants for the converter output port: pin indices, thresholds, timing
// assumes inclusion by sco_pkg.sv and the design module only
`ifndef SCO_MAP_SVH
`define SCO_MAP_SVH

// sampled-level format: unsigned fraction of the reference, 16 bits
`define SCO_WORD_W    8
`define SCO_LEVEL_W   16
`define SCO_PIN_W     19

// pin vector positions
`define SCO_PIN_CLK   0
`define SCO_PIN_OEN   1
`define SCO_PIN_PD    2
`define SCO_PIN_LVL   3

// saturation thresholds as fractions of the reference (0.0665 and 0.75)
`define SCO_LOW_TH    16'h1106
`define SCO_HIGH_TH   16'hC000
// reciprocal of the span, scaled by 2^32, maps the span onto 256 codes
`define SCO_RECIP     33'h1768D
`define SCO_ZERO_CODE 8'h00
`define SCO_FULL_CODE 8'hFF
`define SCO_WORD_RST  8'h00

// timing: core clock period and output delay / hold in ns
`define SCO_CLK_NS    8
`define SCO_OD_NS     14
`define SCO_OH_NS     9
`define SCO_OD_CYC    ((`SCO_OD_NS + `SCO_CLK_NS - 1) / `SCO_CLK_NS)
`define SCO_OH_CYC    ((`SCO_OH_NS + `SCO_CLK_NS - 1) / `SCO_CLK_NS)
`define SCO_UPD_CYC   ((`SCO_OD_CYC > `SCO_OH_CYC) ? `SCO_OD_CYC : `SCO_OH_CYC)

`endif

/* File: sco_output_port.sv */
// converter output port: samples on conversion-clock fall, pipelines the word,
// presents it after rises with output delay, and gates the pin drivers.
// assumes conv_clk_in, oe_n_in, power_down_in and level_in arrive from pins
// and are far slower than core_clk_in (conversion clock well under 1/3 rate).
//
// Notes on behaviour
// - sample input at each conversion clock fall
// - word appears 2.5 cycles after sampling
// - exactly one output word per clock cycle
// - conversion continues regardless of output enable
// - drive outputs only while enable held low
// - high impedance when enable or power-down high
// - below 0.0665 reference gives all zeros
// - above three quarters reference gives all ones
// - eight-bit word, all ones is maximum
// - update after rise, hold old word first
`timescale 1ns/1ns

module sco_output_port
	import sco_pkg::*;
(
	// clock and reset
	input  wire logic              core_clk_in,
	input  wire logic              reset_in,
	// pins from the host side
	input  wire logic              conv_clk_in,
	input  wire logic              oe_n_in,
	input  wire logic              power_down_in,
	input  wire sco_pkg::sco_level_t level_in,
	// parallel output pins, drivers enabled by data_oe_out
	output sco_pkg::sco_word_t     data_out,
	output logic                   data_oe_out
);
	import sco_pkg::*;

	// synchroniser and filtered pin levels
	sco_pins_t      s1_ff, s2_ff, s3_ff, lvl_ff;
	sco_pins_t      nxt_s1, nxt_s2, nxt_s3, nxt_lvl;
	// conversion pipeline
	sco_word_t      samp_ff, stage_a_ff, stage_b_ff;
	sco_word_t      nxt_samp, nxt_stage_a, nxt_stage_b;
	// two-entry buffer
	sco_word_t      buf_ff [2];
	sco_word_t      nxt_buf [2];
	logic           wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
	logic [1:0]     cnt_ff, nxt_cnt;
	// output sequencer and pins
	sco_upd_state_t state_ff, nxt_state;
	logic [1:0]     dly_ff, nxt_dly;
	sco_word_t      pend_ff, nxt_pend, data_ff, nxt_data;
	logic           oe_ff, nxt_oe;

	logic           fall_evt, rise_evt;
	logic           push_valid, push_ready, push_fire;
	logic           pop_valid, pop_ready, pop_fire;
	sco_level_t     level_now, diff;
	logic [32:0]    prod;
	sco_word_t      qcode;

	// per-pin filter: a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < `SCO_PIN_W; gi++) begin : g_pin
			assign nxt_lvl[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : lvl_ff[gi];
		end
	endgenerate

	assign nxt_s1 = {level_in, power_down_in, oe_n_in, conv_clk_in};
	assign nxt_s2 = s1_ff;
	assign nxt_s3 = s2_ff;

	// edges of the filtered conversion clock
	assign fall_evt = lvl_ff[`SCO_PIN_CLK] & ~nxt_lvl[`SCO_PIN_CLK];
	assign rise_evt = ~lvl_ff[`SCO_PIN_CLK] & nxt_lvl[`SCO_PIN_CLK];

	// quantiser with saturation at both ends of the range
	always_comb begin
		level_now = nxt_lvl[`SCO_PIN_LVL +: `SCO_LEVEL_W];
		diff      = level_now - `SCO_LOW_TH;
		prod      = 33'(diff) * `SCO_RECIP;
		if (level_now < `SCO_LOW_TH) begin
			qcode = `SCO_ZERO_CODE;
		end else if (level_now > `SCO_HIGH_TH || prod[32]) begin
			qcode = `SCO_FULL_CODE;
		end else begin
			qcode = prod[31:24];
		end
	end

	// handshake terms; a full buffer stalls the pipeline and drops the sample in samp_ff
	assign push_valid = rise_evt;
	assign push_ready = (cnt_ff != 2'h2);
	assign push_fire  = push_valid & push_ready;
	assign pop_valid  = (cnt_ff != 2'h0);
	assign pop_ready  = (state_ff == SCO_IDLE);
	assign pop_fire   = pop_valid & pop_ready;

	// next-state for pipeline, buffer, sequencer and pin drivers
	always_comb begin
		nxt_samp    = samp_ff;
		nxt_stage_a = stage_a_ff;
		nxt_stage_b = stage_b_ff;
		nxt_buf     = buf_ff;
		nxt_wr_ptr  = wr_ptr_ff;
		nxt_rd_ptr  = rd_ptr_ff;
		nxt_cnt     = cnt_ff;
		nxt_state   = state_ff;
		nxt_dly     = dly_ff;
		nxt_pend    = pend_ff;
		nxt_data    = data_ff;
		// sampling ignores the enable so conversion never pauses
		if (fall_evt) begin
			nxt_samp = qcode;
		end
		// half-cycle plus two rises: 2.5 cycles from sample to pins
		if (push_fire) begin
			nxt_stage_a         = samp_ff;
			nxt_stage_b         = stage_a_ff;
			nxt_buf[wr_ptr_ff]  = stage_b_ff;
			nxt_wr_ptr          = ~wr_ptr_ff;
		end
		if (pop_fire) begin
			nxt_pend   = buf_ff[rd_ptr_ff];
			nxt_rd_ptr = ~rd_ptr_ff;
		end
		nxt_cnt = cnt_ff + {1'b0, push_fire} - {1'b0, pop_fire};
		// old word held through the hold time, new one after output delay
		case (state_ff)
			SCO_IDLE: begin
				if (pop_fire) begin
					nxt_state = SCO_WAIT;
					nxt_dly   = 2'(`SCO_UPD_CYC - 1);
				end
			end
			SCO_WAIT: begin
				if (dly_ff == 2'h0) begin
					nxt_data  = pend_ff;
					nxt_state = SCO_IDLE;
				end else begin
					nxt_dly = dly_ff - 2'h1;
				end
			end
			default: nxt_state = SCO_IDLE;
		endcase
		// drive only with enable low and power-down low
		nxt_oe = ~lvl_ff[`SCO_PIN_OEN] & ~lvl_ff[`SCO_PIN_PD];
	end

	// registers
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			s1_ff      <= '0;
			s2_ff      <= '0;
			s3_ff      <= '0;
			lvl_ff     <= '0;
			samp_ff    <= `SCO_WORD_RST;
			stage_a_ff <= `SCO_WORD_RST;
			stage_b_ff <= `SCO_WORD_RST;
			buf_ff[0]  <= `SCO_WORD_RST;
			buf_ff[1]  <= `SCO_WORD_RST;
			wr_ptr_ff  <= 1'b0;
			rd_ptr_ff  <= 1'b0;
			cnt_ff     <= 2'h0;
			state_ff   <= SCO_IDLE;
			dly_ff     <= 2'h0;
			pend_ff    <= `SCO_WORD_RST;
			data_ff    <= `SCO_WORD_RST;
			oe_ff      <= 1'b0;
		end else begin
			s1_ff      <= nxt_s1;
			s2_ff      <= nxt_s2;
			s3_ff      <= nxt_s3;
			lvl_ff     <= nxt_lvl;
			samp_ff    <= nxt_samp;
			stage_a_ff <= nxt_stage_a;
			stage_b_ff <= nxt_stage_b;
			buf_ff     <= nxt_buf;
			wr_ptr_ff  <= nxt_wr_ptr;
			rd_ptr_ff  <= nxt_rd_ptr;
			cnt_ff     <= nxt_cnt;
			state_ff   <= nxt_state;
			dly_ff     <= nxt_dly;
			pend_ff    <= nxt_pend;
			data_ff    <= nxt_data;
			oe_ff      <= nxt_oe;
		end
	end

	assign data_out    = data_ff;
	assign data_oe_out = oe_ff;

	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	property p_sample_fall;
		fall_evt |=> samp_ff == $past(qcode);
	endproperty
	a_sample_fall: assert property (p_sample_fall) else $error("sample missed");

	property p_pipe_shift;
		push_fire |=> stage_a_ff == $past(samp_ff) && stage_b_ff == $past(stage_a_ff);
	endproperty
	a_pipe_shift: assert property (p_pipe_shift) else $error("pipeline slip");

	property p_one_word;
		push_fire && !pop_fire |=> cnt_ff == $past(cnt_ff) + 2'h1;
	endproperty
	a_one_word: assert property (p_one_word) else $error("word lost");

	property p_convert_disabled;
		fall_evt && lvl_ff[`SCO_PIN_OEN] |=> samp_ff == $past(qcode) && !data_oe_out;
	endproperty
	a_convert_disabled: assert property (p_convert_disabled) else $error("stalled");

	property p_drive_cause;
		data_oe_out |-> $past(!lvl_ff[`SCO_PIN_OEN] && !lvl_ff[`SCO_PIN_PD]);
	endproperty
	a_drive_cause: assert property (p_drive_cause) else $error("driven wrongly");

	property p_hiz;
		lvl_ff[`SCO_PIN_OEN] || lvl_ff[`SCO_PIN_PD] |=> !data_oe_out;
	endproperty
	a_hiz: assert property (p_hiz) else $error("not released");

	property p_zero;
		fall_evt && level_now < `SCO_LOW_TH |=> samp_ff == `SCO_ZERO_CODE;
	endproperty
	a_zero: assert property (p_zero) else $error("no zero clamp");

	property p_full;
		fall_evt && level_now > `SCO_HIGH_TH |=> samp_ff == `SCO_FULL_CODE;
	endproperty
	a_full: assert property (p_full) else $error("no full clamp");

	property p_update_time;
		pop_fire |=> $stable(data_ff) [*2] ##1 data_ff == $past(pend_ff);
	endproperty
	a_update_time: assert property (p_update_time) else $error("early update");

	// further checks on rate, gating, clamping and hold; a stall at a rise
	// would silently drop a word, so the buffer must always have room then
	property p_no_stall;
		rise_evt |-> push_ready;
	endproperty
	a_no_stall: assert property (p_no_stall) else $error("buffer full at a rise");

	property p_cnt_bound;
		cnt_ff != 2'h3;
	endproperty
	a_cnt_bound: assert property (p_cnt_bound) else $error("buffer count overrun");

	property p_pop_order;
		pop_fire |=> pend_ff == $past(buf_ff[rd_ptr_ff]);
	endproperty
	a_pop_order: assert property (p_pop_order) else $error("buffer order broken");

	property p_oe_follow;
		!lvl_ff[`SCO_PIN_OEN] && !lvl_ff[`SCO_PIN_PD] |=> data_oe_out;
	endproperty
	a_oe_follow: assert property (p_oe_follow) else $error("drivers not enabled");

	property p_pd_release;
		$rose(lvl_ff[`SCO_PIN_PD]) |=> !data_oe_out;
	endproperty
	a_pd_release: assert property (p_pd_release) else $error("power-down kept drive");

	// the clamps are checked on the quantiser itself, not only at samples
	property p_clamp_low;
		level_now < `SCO_LOW_TH |-> qcode == `SCO_ZERO_CODE;
	endproperty
	a_clamp_low: assert property (p_clamp_low) else $error("low clamp missing");

	property p_clamp_high;
		level_now > `SCO_HIGH_TH |-> qcode == `SCO_FULL_CODE;
	endproperty
	a_clamp_high: assert property (p_clamp_high) else $error("high clamp missing");

	property p_max_code;
		&level_now |-> qcode == `SCO_FULL_CODE;
	endproperty
	a_max_code: assert property (p_max_code) else $error("maximum not all ones");

	property p_hold_old;
		rise_evt |=> $stable(data_ff) [*3];
	endproperty
	a_hold_old: assert property (p_hold_old) else $error("old word not held");

	property p_update_only;
		$changed(data_ff) |-> $past(state_ff == SCO_WAIT && dly_ff == 2'h0);
	endproperty
	a_update_only: assert property (p_update_only) else $error("update outside delay");

	property p_filter_clk;
		$changed(lvl_ff[`SCO_PIN_CLK]) |-> $past(s2_ff[`SCO_PIN_CLK] == s3_ff[`SCO_PIN_CLK]);
	endproperty
	a_filter_clk: assert property (p_filter_clk) else $error("clock edge unfiltered");

	c_zero: cover property (fall_evt && level_now < `SCO_LOW_TH);
	c_full: cover property (fall_evt && level_now > `SCO_HIGH_TH);
	c_buf_full: cover property (cnt_ff == 2'h2);
	c_driving: cover property (data_oe_out && $changed(data_ff));
	c_dark_sample: cover property (fall_evt && lvl_ff[`SCO_PIN_OEN]);
endmodule : sco_output_port

/* File: sco_output_port_bench.sv */
// testbench for the converter output port with the host model
// assumes the design samples on clock falls and answers after three rises
`timescale 1ns/1ns

module sco_output_port_bench;
	import sco_pkg::*;

	logic       core_clk_in, reset_in, oe_n_in, power_down_in, run, en_now;
	logic       conv_clk, data_oe_out, rise;
	sco_level_t level_in;
	sco_word_t  data_out, cap;
	int         err_total = 0;
	int         num_checks = 0;
	int         cycles = 0;
	sco_level_t hist[$];

	sco_output_port uut (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.conv_clk_in(conv_clk), .oe_n_in(oe_n_in), .power_down_in(power_down_in),
		.level_in(level_in), .data_out(data_out), .data_oe_out(data_oe_out));

	sco_host_model #(.HALF(10)) host (.core_clk_in(core_clk_in), .run_in(run),
		.data_in(data_out), .data_oe_in(data_oe_out), .conv_clk_out(conv_clk),
		.rise_out(rise), .cap_out(cap));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	// linear law between the two saturation points
	function automatic sco_word_t quant(input sco_level_t l);
		logic [40:0] p;
		p = (41'(l) - 41'h1106) * 41'h1768D;
		if (l < 16'h1106) return 8'h00;
		if (l > 16'hC000) return 8'hFF;
		// the top of the span overflows the scaled product: still full scale
		if (p[40:32] != 9'h000) return 8'hFF;
		return p[31:24];
	endfunction : quant

	// one conversion rise: judge the capture, then set the next level
	task automatic step(input sco_level_t lvl, input logic oe_n_v, input logic pd_v);
		int n;
		do begin
			@(posedge core_clk_in);
			#1;
		end while (!rise);
		n = hist.size();
		if (en_now) begin
			check(8'(data_oe_out), 8'h01);
			if (n >= 4) check(cap, quant(hist[n-4]));
		end else check(8'(data_oe_out), 8'h00);
		hist.push_back(lvl);
		level_in = lvl;
		oe_n_in = oe_n_v;
		power_down_in = pd_v;
		en_now = !oe_n_v && !pd_v;
	endtask : step

	// boundaries of both saturation points and mid-range codes
	task automatic scen_saturation();
		sco_level_t t[9] = '{16'h0000, 16'h1105, 16'h1106, 16'h1107, 16'h6000,
			16'hBFFF, 16'hC001, 16'hFFFF, 16'h8000};
		foreach (t[i]) step(t[i], 1'b0, 1'b0);
	endtask : scen_saturation

	// words sampled while the pins float must still come out later
	task automatic scen_gating();
		step(16'h3000, 1'b1, 1'b0);
		step(16'h5000, 1'b1, 1'b0);
		step(16'h7000, 1'b0, 1'b1);
		step(16'h9000, 1'b1, 1'b1);
		repeat (6) step(16'h2000, 1'b0, 1'b0);
	endtask : scen_gating

	task automatic finish_test();
		if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	// 8 ns core clock
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	// cut a hang short; the tests need about 400 cycles
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		reset_in = 1'b1;
		oe_n_in = 1'b0;
		power_down_in = 1'b0;
		level_in = 16'h0000;
		run = 1'b0;
		en_now = 1'b1;
		repeat (6) @(posedge core_clk_in);
		#1;
		reset_in = 1'b0;
		run = 1'b1;
		scen_saturation();
		scen_gating();
		finish_test();
	end
endmodule : sco_output_port_bench

/* File: sco_pkg.sv */
// types for the converter output port
// assumes sco_map.svh is reachable on the include path
`include "sco_map.svh"

package sco_pkg;
	typedef logic [`SCO_WORD_W-1:0]  sco_word_t;
	typedef logic [`SCO_LEVEL_W-1:0] sco_level_t;
	typedef logic [`SCO_PIN_W-1:0]   sco_pins_t;

	// output update sequencer
	typedef enum logic [0:0] {
		SCO_IDLE = 1'b0,
		SCO_WAIT = 1'b1
	} sco_upd_state_t;
endpackage : sco_pkg
